// File: pkg/eecc_map.vh
// Register map, field positions, reset values and timing of the EEPROM command block
`ifndef EECC_MAP_VH
`define EECC_MAP_VH

// Byte offsets
`define EECC_OFF_CMD 8'hb0
`define EECC_OFF_DATA 8'hb4
`define EECC_OFF_INT_STS 8'hb8
`define EECC_OFF_INT_CLR 8'hbc
`define EECC_OFF_INT_EN 8'hc0
`define EECC_OFF_MAC_LO 8'hc4
`define EECC_OFF_MAC_HI 8'hc8

// Command register fields
`define EECC_CMD_BUSY_BIT 31
`define EECC_CMD_CODE_HI 30
`define EECC_CMD_CODE_LO 28
`define EECC_CMD_TMO_BIT 9
`define EECC_CMD_MACOK_BIT 8
`define EECC_CMD_ADDR_HI 7
`define EECC_CMD_ADDR_LO 0

// Command codes
`define EECC_CODE_READ 3'h0
`define EECC_CODE_WRITE 3'h3

// Interrupt status bit positions
`define EECC_INT_DONE 0
`define EECC_INT_TMO 1
`define EECC_INT_MAC 2
`define EECC_INT_W 3

// Reset values
`define EECC_RST_BUSY 1'b1
`define EECC_RST_INT_EN 3'h0

// Automatic MAC address load
`define EECC_MAC_BASE 8'h01
`define EECC_MAC_BYTES 6

// Time-out: time in microseconds, clock in MHz, count derived from both
`define EECC_TIMEOUT_US 30000
`define EECC_CLK_MHZ 50
`define EECC_TIMEOUT_CYC (`EECC_TIMEOUT_US * `EECC_CLK_MHZ)

`endif

// File: hw/eecc_timer.v
// Time-out counter for one EEPROM operation
`timescale 1ns/1ps
module eecc_timer #(
   parameter COUNT = 1500000,
   parameter CW = 32
) (
   clk_sys, // System clock
   rst, // Synchronous reset, active high
   start, // Pulse: (re)load and run
   stop, // Pulse: halt without expiring
   expired_r // Pulse: count ran out
);
   input wire clk_sys;
   input wire rst;
   input wire start;
   input wire stop;
   output reg expired_r;

   localparam [CW-1:0] LOAD = COUNT - 1;
   reg [CW-1:0] count_r;
   reg running_r;

   always @(posedge clk_sys) begin
      if (rst) begin
         count_r <= {CW{1'b0}};
         running_r <= 1'b0;
         expired_r <= 1'b0;
      end else begin
         expired_r <= 1'b0;
         if (start) begin
            count_r <= LOAD;
            running_r <= 1'b1;
         end else if (stop) begin
            running_r <= 1'b0;
         end else if (running_r) begin
            if (count_r == {CW{1'b0}}) begin
               running_r <= 1'b0;
               expired_r <= 1'b1;
            end else begin
               count_r <= count_r - {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // eecc_timer

// File: hw/eecc_irq.v
// Sticky interrupt status, enable mask and level interrupt output
`timescale 1ns/1ps
module eecc_irq #(
   parameter W = 3
) (
   clk_sys, // System clock
   rst, // Synchronous reset, active high
   event_i, // Event pulses, one per bit
   clr_wr, // Pulse: write to clear register
   en_wr, // Pulse: write to enable register
   wr_bits, // Write data for clear or enable
   status_r, // Sticky status
   enable_r, // Enable mask
   irq_r // Level interrupt
);
   input wire clk_sys;
   input wire rst;
   input wire [W-1:0] event_i;
   input wire clr_wr;
   input wire en_wr;
   input wire [W-1:0] wr_bits;
   output reg [W-1:0] status_r;
   output reg [W-1:0] enable_r;
   output reg irq_r;

   reg [W-1:0] status_nxt;

   // Set beats clear so a coincident event survives
   always @* begin
      status_nxt = status_r;
      if (clr_wr)
         status_nxt = status_nxt & ~wr_bits;
      status_nxt = status_nxt | event_i;
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         status_r <= {W{1'b0}};
         enable_r <= {W{1'b0}};
         irq_r <= 1'b0;
      end else begin
         status_r <= status_nxt;
         if (en_wr)
            enable_r <= wr_bits;
         irq_r <= |(status_nxt & (en_wr ? wr_bits : enable_r));
      end
   end
endmodule // eecc_irq

// File: hw/eecc_top.v
// EEPROM command and busy control with automatic MAC address load
//
// What this block does
// R1: Writing one to bit 31 launches the selected read or write command at the given address; other codes are ignored.
// R2: Busy stays one for the whole operation, clears itself when it ends.
// R3: On a read, busy clearing means the data register holds valid data.
// R4: Software leaves command and data registers alone while busy is one.
// R5: A write with no EEPROM keeps busy until time-out, then clears it.
// R6: Busy reads as one straight after reset.
// R7: After reset the MAC address is loaded; busy clears when done or failed.
// R8: Every operation starts a time-out; expiry aborts it and releases busy.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "eecc_map.vh"
module eecc_top #(
   parameter TIMEOUT_CYC = `EECC_TIMEOUT_CYC,
   parameter AW = 8,
   parameter DW = 8
) (
   clk_sys, // System clock, 50 MHz
   rst, // Synchronous reset, active high
   reg_addr, // Register byte address
   reg_wdata, // Register write data
   reg_wr, // Write strobe
   reg_rd, // Read strobe
   reg_rdata_r, // Read data, cycle after strobe
   irq_r, // Level interrupt
   ee_req_r, // Pulse: start one word access
   ee_we_r, // Access is a write
   ee_addr_r, // EEPROM word address
   ee_wdata_r, // EEPROM write data
   ee_done, // Pulse: access finished
   ee_rdata // EEPROM read data, valid with done
);
   input wire clk_sys;
   input wire rst;
   input wire [7:0] reg_addr;
   input wire [31:0] reg_wdata;
   input wire reg_wr;
   input wire reg_rd;
   output reg [31:0] reg_rdata_r;
   output wire irq_r;
   output reg ee_req_r;
   output reg ee_we_r;
   output reg [AW-1:0] ee_addr_r;
   output reg [DW-1:0] ee_wdata_r;
   input wire ee_done;
   input wire [DW-1:0] ee_rdata;

   ////////////////////////////////////////////////////////////////////////
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_ISSUE = 3'b010;
   localparam [2:0] ST_WAIT = 3'b100;
   localparam [31:0] MAC_LAST_W = `EECC_MAC_BYTES - 1;
   localparam [2:0] MAC_LAST = MAC_LAST_W[2:0];

   function supported;
      input [2:0] code;
      begin
         supported = (code == `EECC_CODE_READ) || (code == `EECC_CODE_WRITE);
      end
   endfunction

   function hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   reg [2:0] state_r;
   reg busy_r;
   reg mac_mode_r;
   reg [2:0] mac_idx_r;
   reg [47:0] mac_r;
   reg mac_ok_r;
   reg tmo_r;
   reg [2:0] code_r;
   reg [AW-1:0] addr_r;
   reg [DW-1:0] data_r;
   reg [`EECC_INT_W-1:0] ev_r;

   wire expired;
   wire [`EECC_INT_W-1:0] int_sts;
   wire [`EECC_INT_W-1:0] int_en;

   wire wr_cmd = reg_wr && hit(reg_addr, `EECC_OFF_CMD);
   wire wr_data = reg_wr && hit(reg_addr, `EECC_OFF_DATA);
   wire wr_clr = reg_wr && hit(reg_addr, `EECC_OFF_INT_CLR);
   wire wr_en = reg_wr && hit(reg_addr, `EECC_OFF_INT_EN);
   wire [2:0] new_code = reg_wdata[`EECC_CMD_CODE_HI:`EECC_CMD_CODE_LO];
   // R1: launch on start bit
   wire launch = wr_cmd && reg_wdata[`EECC_CMD_BUSY_BIT] && !busy_r && supported(new_code);
   wire issue = (state_r == ST_ISSUE);
   wire wait_done = (state_r == ST_WAIT) && ee_done;

   ////////////////////////////////////////////////////////////////////////
   // R8: time-out per access
   eecc_timer #(
      .COUNT(TIMEOUT_CYC),
      .CW(32)
   ) u_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(issue),
      .stop(wait_done),
      .expired_r(expired)
   );

   eecc_irq #(
      .W(`EECC_INT_W)
   ) u_irq (
      .clk_sys(clk_sys),
      .rst(rst),
      .event_i(ev_r),
      .clr_wr(wr_clr),
      .en_wr(wr_en),
      .wr_bits(reg_wdata[`EECC_INT_W-1:0]),
      .status_r(int_sts),
      .enable_r(int_en),
      .irq_r(irq_r)
   );

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      if (rst) begin
         // R6: busy right out of reset
         busy_r <= `EECC_RST_BUSY;
         // R7: reset starts the MAC load
         state_r <= ST_ISSUE;
         mac_mode_r <= 1'b1;
         mac_idx_r <= 3'h0;
         mac_r <= 48'h0;
         mac_ok_r <= 1'b0;
         tmo_r <= 1'b0;
         code_r <= `EECC_CODE_READ;
         addr_r <= {AW{1'b0}};
         data_r <= {DW{1'b0}};
         ev_r <= {`EECC_INT_W{1'b0}};
         ee_req_r <= 1'b0;
         ee_we_r <= 1'b0;
         ee_addr_r <= {AW{1'b0}};
         ee_wdata_r <= {DW{1'b0}};
      end else begin
         ev_r <= {`EECC_INT_W{1'b0}};
         ee_req_r <= 1'b0;
         // R4: data held while busy
         if (wr_data && !busy_r)
            data_r <= reg_wdata[DW-1:0];
         case (state_r)
            ST_IDLE: begin
               if (launch) begin
                  // R2: busy set for the operation
                  busy_r <= 1'b1;
                  tmo_r <= 1'b0;
                  code_r <= new_code;
                  addr_r <= reg_wdata[AW-1:0];
                  state_r <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               ee_req_r <= 1'b1;
               if (mac_mode_r) begin
                  ee_we_r <= 1'b0;
                  ee_addr_r <= `EECC_MAC_BASE + {5'h0, mac_idx_r};
               end else begin
                  ee_we_r <= (code_r == `EECC_CODE_WRITE);
                  ee_addr_r <= addr_r;
               end
               ee_wdata_r <= data_r;
               state_r <= ST_WAIT;
            end
            ST_WAIT: begin
               if (ee_done) begin
                  if (mac_mode_r) begin
                     mac_r[{mac_idx_r, 3'h0} +: 8] <= ee_rdata[7:0];
                     if (mac_idx_r == MAC_LAST) begin
                        // R7: load finished, release busy
                        mac_mode_r <= 1'b0;
                        mac_ok_r <= 1'b1;
                        busy_r <= 1'b0;
                        ev_r[`EECC_INT_MAC] <= 1'b1;
                        state_r <= ST_IDLE;
                     end else begin
                        mac_idx_r <= mac_idx_r + 3'h1;
                        state_r <= ST_ISSUE;
                     end
                  end else begin
                     // R3: read data valid as busy drops
                     if (code_r == `EECC_CODE_READ)
                        data_r <= ee_rdata;
                     // R2: clear when complete
                     busy_r <= 1'b0;
                     ev_r[`EECC_INT_DONE] <= 1'b1;
                     state_r <= ST_IDLE;
                  end
               end else if (expired) begin
                  // R5: absent EEPROM ends in time-out
                  // R8: abort and release busy
                  busy_r <= 1'b0;
                  tmo_r <= 1'b1;
                  ev_r[`EECC_INT_TMO] <= 1'b1;
                  if (mac_mode_r) begin
                     // R7: failed load also releases busy
                     mac_mode_r <= 1'b0;
                     mac_ok_r <= 1'b0;
                     ev_r[`EECC_INT_MAC] <= 1'b1;
                  end
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               busy_r <= 1'b0;
               mac_mode_r <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Unmapped and write-only offsets read as zero
   always @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata_r <= 32'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            `EECC_OFF_CMD: begin
               reg_rdata_r <= 32'h0;
               reg_rdata_r[`EECC_CMD_BUSY_BIT] <= busy_r;
               reg_rdata_r[`EECC_CMD_CODE_HI:`EECC_CMD_CODE_LO] <= code_r;
               reg_rdata_r[`EECC_CMD_TMO_BIT] <= tmo_r;
               reg_rdata_r[`EECC_CMD_MACOK_BIT] <= mac_ok_r;
               reg_rdata_r[`EECC_CMD_ADDR_HI:`EECC_CMD_ADDR_LO] <= addr_r;
            end
            `EECC_OFF_DATA: reg_rdata_r <= {{(32-DW){1'b0}}, data_r};
            `EECC_OFF_INT_STS: reg_rdata_r <= {{(32-`EECC_INT_W){1'b0}}, int_sts};
            `EECC_OFF_INT_EN: reg_rdata_r <= {{(32-`EECC_INT_W){1'b0}}, int_en};
            `EECC_OFF_MAC_LO: reg_rdata_r <= mac_r[31:0];
            `EECC_OFF_MAC_HI: reg_rdata_r <= {16'h0, mac_r[47:32]};
            default: reg_rdata_r <= 32'h0;
         endcase
      end else begin
         reg_rdata_r <= 32'h0;
      end
   end
endmodule // eecc_top

// File: sim/eecc_chk.sv
// Port checker for the EEPROM command block
`timescale 1ns/1ps
`include "eecc_map.vh"
module eecc_chk #(
   parameter TIMEOUT_CYC = 20,
   parameter AW = 8,
   parameter DW = 8
) (
   input wire clk_sys, // Clock
   input wire rst, // Reset
   input wire [7:0] reg_addr, // Address
   input wire [31:0] reg_wdata, // Write data
   input wire reg_wr, // Write strobe
   input wire reg_rd, // Read strobe
   input wire [31:0] reg_rdata_r, // Read data
   input wire irq_r, // Interrupt
   input wire ee_req_r, // Access start
   input wire ee_we_r, // Write access
   input wire [AW-1:0] ee_addr_r, // Word address
   input wire [DW-1:0] ee_wdata_r, // Write data
   input wire ee_done, // Access end
   input wire [DW-1:0] ee_rdata // Read data
);
   reg wait_r;
   reg [31:0] cnt_r;
   reg [7:0] cmd_addr_r;
   reg [DW-1:0] data_r;
//////////
   // Access counted open until answer or time-out
   always @(posedge clk_sys) begin
      if (reg_wr && reg_addr == `EECC_OFF_CMD) cmd_addr_r <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `EECC_OFF_DATA) data_r <= reg_wdata[DW-1:0];
      if (rst) begin
         wait_r <= 1'b0;
         cnt_r <= 32'h0;
      end else if (ee_req_r) begin
         wait_r <= 1'b1;
         cnt_r <= 32'h0;
      end else if (ee_done || cnt_r == TIMEOUT_CYC) begin
         wait_r <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end
//////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_boot_load: assert property ($fell(rst) |-> ##[0:1] (ee_req_r && ee_addr_r == `EECC_MAC_BASE))
      else $error("boot load not started");
   chk_req_pulse: assert property (ee_req_r |=> !ee_req_r)
      else $error("request longer than one cycle");
   chk_one_open: assert property (ee_req_r |-> !wait_r)
      else $error("request while access open");
   chk_req_hold: assert property (wait_r && !ee_req_r |-> $stable(ee_addr_r) && $stable(ee_we_r))
      else $error("access fields moved");
   chk_done_gap: assert property (ee_done && wait_r |=> !ee_req_r)
      else $error("request right after done");
   chk_wr_fields: assert property (ee_req_r && ee_we_r |-> ee_addr_r == cmd_addr_r && ee_wdata_r == data_r)
      else $error("write access fields wrong");
   chk_rd_window: assert property (reg_rdata_r != 32'h0 |-> $past(reg_rd))
      else $error("read data outside window");
   chk_irq_fall: assert property ($fell(irq_r) |-> $past(reg_wr))
      else $error("interrupt fell by itself");
endmodule // eecc_chk
bind eecc_top eecc_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .AW(AW), .DW(DW)) u_chk (.clk_sys(clk_sys), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
   .irq_r(irq_r), .ee_req_r(ee_req_r), .ee_we_r(ee_we_r), .ee_addr_r(ee_addr_r), .ee_wdata_r(ee_wdata_r),
   .ee_done(ee_done), .ee_rdata(ee_rdata));

// File: sim/eecc_ee_model.sv
// Behavioural serial EEPROM engine for the bench
`timescale 1ns/1ps
module eecc_ee_model (
   input wire clk_sys, // Clock
   input wire rst, // Reset
   input wire req, // Access start
   input wire we, // Write access
   input wire [7:0] addr, // Word address
   input wire [7:0] wdata, // Write data
   input wire present, // Device fitted
   input wire [7:0] lat, // Answer delay
   output reg done = 1'b0, // Access end
   output reg [7:0] rdata = 8'h00 // Read data
);
   reg [7:0] mem [0:255];
   reg [7:0] cnt;
   reg busy;
   integer i;
   initial for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'h5a;
   // Data toggles outside answers so stale values never match
   always @(posedge clk_sys) begin
      done <= 1'b0;
      rdata <= ~rdata;
      if (rst) begin
         busy <= 1'b0;
      end else if (req) begin
         busy <= present;
         cnt <= lat;
      end else if (busy && cnt == 8'h00) begin
         busy <= 1'b0;
         done <= 1'b1;
         if (we) mem[addr] <= wdata;
         else rdata <= mem[addr];
      end else if (busy) begin
         cnt <= cnt - 8'h01;
      end
   end
endmodule // eecc_ee_model

// File: sim/tb.sv
// Self-checking bench for the EEPROM command block
`timescale 1ns/1ps
`include "eecc_map.vh"
module tb;
   localparam TMO = 20;
   reg clk_sys = 1'b0;
   reg rst = 1'b1;
   reg [7:0] reg_addr = 8'h00;
   reg [31:0] reg_wdata = 32'h0;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg present = 1'b1;
   reg [7:0] lat = 8'h02;
   wire [31:0] reg_rdata_r;
   wire irq_r, ee_req_r, ee_we_r, ee_done;
   wire [7:0] ee_addr_r, ee_wdata_r, ee_rdata;
   reg [31:0] rv;
   integer n_mismatch = 0;
   integer num_checks = 0;
   integer cyc = 0;
   always #10 clk_sys = ~clk_sys;
//////////
   eecc_top #(.TIMEOUT_CYC(TMO)) dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .irq_r(irq_r),
      .ee_req_r(ee_req_r), .ee_we_r(ee_we_r), .ee_addr_r(ee_addr_r), .ee_wdata_r(ee_wdata_r),
      .ee_done(ee_done), .ee_rdata(ee_rdata));
   eecc_ee_model peer (.clk_sys(clk_sys), .rst(rst), .req(ee_req_r), .we(ee_we_r), .addr(ee_addr_r),
      .wdata(ee_wdata_r), .present(present), .lat(lat), .done(ee_done), .rdata(ee_rdata));
//////////
   function [7:0] ee(input [7:0] a);
      ee = a ^ 8'h5a;
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk_sys);
         reg_wr <= 1'b0;
         // Edge between writes keeps one strobe assignment per step
         @(posedge clk_sys);
      end
   endtask
   task rd(input [7:0] a);
      begin
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk_sys);
         reg_rd <= 1'b0;
         #1 rv = reg_rdata_r;
         @(posedge clk_sys);
      end
   endtask
   task go(input [2:0] code, input [7:0] a);
      wr(`EECC_OFF_CMD, {1'b1, code, 20'h0, a});
   endtask
   // Polling bounded; leaves the last command word in rv
   task idle(input integer lim);
      integer k;
      begin
         rv = 32'h8000_0000;
         for (k = 0; k < lim && rv[31]; k = k + 1) rd(`EECC_OFF_CMD);
         chk(rv >> 31, 32'h0);
      end
   endtask
   task irq_is(input e);
      begin
         @(negedge clk_sys);
         chk({31'h0, irq_r}, {31'h0, e});
         @(posedge clk_sys);
      end
   endtask
//////////
   task s_boot(input p);
      begin
         present <= p;
         rst <= 1'b1;
         repeat (16) @(posedge clk_sys);
         rst <= 1'b0;
         rd(`EECC_OFF_CMD);
         chk(rv >> 31, 32'h1);
         idle(80);
         chk((rv >> 8) & 32'h3, p ? 32'h1 : 32'h2);
         rd(`EECC_OFF_INT_STS);
         chk(rv & 32'h6, p ? 32'h4 : 32'h6);
         if (p) begin
            rd(`EECC_OFF_MAC_LO);
            chk(rv, {ee(8'h04), ee(8'h03), ee(8'h02), ee(8'h01)});
            rd(`EECC_OFF_MAC_HI);
            chk(rv, {16'h0, ee(8'h06), ee(8'h05)});
         end
         wr(`EECC_OFF_INT_CLR, 32'h7);
      end
   endtask
   task s_read(input [7:0] a, input [7:0] e);
      begin
         go(`EECC_CODE_READ, a);
         rd(`EECC_OFF_CMD);
         chk(rv >> 31, 32'h1);
         idle(40);
         rd(`EECC_OFF_DATA);
         chk(rv & 32'hff, {24'h0, e});
         rd(`EECC_OFF_INT_STS);
         chk(rv & 32'h1, 32'h1);
      end
   endtask
   task s_write(input [7:0] a, input [7:0] d);
      begin
         wr(`EECC_OFF_DATA, {24'h0, d});
         go(`EECC_CODE_WRITE, a);
         idle(40);
         s_read(a, d);
      end
   endtask
   task s_tmo;
      begin
         present <= 1'b0;
         wr(`EECC_OFF_INT_CLR, 32'h7);
         wr(`EECC_OFF_INT_EN, 32'h1);
         wr(`EECC_OFF_DATA, 32'h11);
         go(`EECC_CODE_WRITE, 8'h30);
         repeat (TMO - 6) @(posedge clk_sys);
         rd(`EECC_OFF_CMD);
         chk(rv >> 31, 32'h1);
         idle(20);
         chk((rv >> 9) & 32'h1, 32'h1);
         irq_is(1'b0);
         rd(`EECC_OFF_INT_STS);
         chk(rv & 32'h2, 32'h2);
         present <= 1'b1;
         s_read(8'h31, ee(8'h31));
         irq_is(1'b1);
         wr(`EECC_OFF_INT_CLR, 32'h1);
         irq_is(1'b0);
         rd(`EECC_OFF_INT_EN);
         chk(rv, 32'h1);
         rd(8'hfc);
         chk(rv, 32'h0);
      end
   endtask
   // Unsupported code with start bit must not launch
   task s_reject;
      begin
         go(3'h1, 8'h40);
         rd(`EECC_OFF_CMD);
         chk(rv >> 31, 32'h0);
         rd(`EECC_OFF_INT_STS);
         chk(rv & 32'h1, 32'h0);
      end
   endtask
//////////
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_mismatch);
         if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      s_boot(1'b1);
      lat <= 8'h0a;
      s_read(8'h20, ee(8'h20));
      lat <= 8'h00;
      s_write(8'haa, 8'h55);
      s_tmo;
      s_reject;
      s_boot(1'b0);
      wrap_up;
   end
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         n_mismatch = n_mismatch + 1;
         wrap_up;
      end
   end
endmodule // tb
